// file: src/dsas_seq.sv
// dual-slope converter sequencer: top level
// assumes analog switches, integrator and comparator outside this block
//
// Functional notes
// [R1] hold high or open: free-run, a new cycle every 40002 counts
// [R2] hold low: finish the running conversion, then keep result, no restart
// [R3] hold pulse over 300 ns starts one cycle with 9001-10001 auto-zero
// [R4] pulse ending before the cycle completes is ignored
// [R5] first digit strobe 101 counts after cycle end; idle after that
// [R6] integrate exactly 10000 counts, then clear counter, switch reference
// [R7] deintegrate counts until comparator reports zero; count is result
// [R8] after zero crossing, auto-zero integrator and comparator
// [R9] hold low suppresses the restart of the counters
// [R10] ratio mode uses external reference, reading signal/ref times 10000
// [R11] blank input low blanks digits; open shows them
// [R12] sign and points never blanked; flash above 19999 counts; here sign and points go dark with the digits in the flash
// [R13] exactly one of four decimal points, jumper or connector tie; none lit here while the overrange flash is dark
// [R14] counting clock from internal 100 kHz oscillator, also output
// [R15] blanking touches only the four low digits
// [R16] overrange flashes the four low digits
// [R17] asynchronous hold and blank pass synchronisers first
// [R18] final count latched into display register after deintegrate
`timescale 1ns/10ps
module dsas_seq #(
  parameter int unsigned CYCLE  = dsas_pkg::CYCLE_COUNTS,
  parameter int unsigned INTEG  = dsas_pkg::INT_COUNTS,
  parameter int unsigned AZ_LEN = dsas_pkg::AZ_START,
  parameter int unsigned FLASH  = dsas_pkg::FLASH_TICKS
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_ce,
  input  wire dsas_pkg::dsas_bus_s    i_bus,
  input  wire logic                   i_hold,
  input  wire logic                   i_blank_n,
  input  wire logic                   i_cmp_zero,
  input  wire logic                   i_sig_neg,
  input  wire logic [3:0]             i_dp_sel_n,
  output logic      [31:0]            o_rdata,
  output logic                        o_osc_100k,
  output logic                        o_sig_sw,
  output logic                        o_ref_sw,
  output logic                        o_az_sw,
  output logic                        o_ref_ext,
  output logic                        o_digit_strobe,
  output dsas_pkg::dsas_result_s      o_disp,
  output logic      [4:0]             o_digit_en,
  output logic                        o_sign_on,
  output logic      [3:0]             o_dp
);
  import dsas_pkg::*;

  typedef enum {
    ST_AZ,
    ST_INT,
    ST_DEINT,
    ST_AZ_END,
    ST_HELD
  } dsas_state_e;

  logic              rst_a_r;
  logic              rst_b_r;
  logic              rst_n;
  logic [7:0]        sync_q;
  logic              hold_s;
  logic              blank_s;
  logic              zero_s;
  logic              neg_s;

  logic [7:0]        div_r;
  logic [7:0]        div_nxt;
  logic              osc_nxt;
  logic              tick_r;
  logic              tick_nxt;

  dsas_state_e       state_r;
  dsas_state_e       state_nxt;
  logic [CNT_W-1:0]  cyc_r;
  logic [CNT_W-1:0]  cyc_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              neg_r;
  logic              neg_nxt;
  dsas_result_s      disp_nxt;
  logic              hold_q_r;
  logic              pend_r;
  logic              pend_nxt;
  logic [7:0]        post_r;
  logic [7:0]        post_nxt;
  logic              post_run_r;
  logic              post_run_nxt;
  logic              strobe_nxt;
  logic              end_cyc;

  logic [3:0]        ctrl_r;
  logic [3:0]        ctrl_nxt;
  logic [31:0]       rdata_nxt;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end
  assign rst_n = rst_b_r;

  dsas_sync #(
    .W       (8),
    .RST_VAL (8'hF3)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_ce       (i_ce),
    .i_async    ({i_dp_sel_n, i_sig_neg, i_cmp_zero, i_blank_n, i_hold}),
    .o_sync     (sync_q)
  );                                                      // [R17]
  assign hold_s  = sync_q[0];
  assign blank_s = sync_q[1];
  assign zero_s  = sync_q[2];
  assign neg_s   = sync_q[3];

  // ----------------------------------------------------------------
  // 100 kHz oscillator and count tick
  // ----------------------------------------------------------------
  always_comb begin
    tick_nxt = (div_r == 8'(OSC_DIV - 1));
    div_nxt  = tick_nxt ? 8'h00 : div_r + 8'h01;
    osc_nxt  = o_osc_100k;
    if (div_r == 8'(OSC_HALF - 1) || tick_nxt) begin
      osc_nxt = ~o_osc_100k;                              // [R14]
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r      <= '0;
      tick_r     <= 1'b0;
      o_osc_100k <= 1'b0;
    end else if (i_ce) begin
      div_r      <= div_nxt;
      tick_r     <= tick_nxt;
      o_osc_100k <= osc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    cyc_nxt      = cyc_r;
    cnt_nxt      = cnt_r;
    neg_nxt      = neg_r;
    disp_nxt     = o_disp;
    post_nxt     = post_r;
    post_run_nxt = post_run_r;
    strobe_nxt   = 1'b0;
    end_cyc      = 1'b0;
    pend_nxt     = pend_r;
    if (tick_r) begin
      if (state_r != ST_HELD) begin
        cyc_nxt = cyc_r + 1'b1;
      end
      case (state_r)
        ST_AZ: begin
          if (cyc_r == CNT_W'(AZ_LEN - 1)) begin
            state_nxt = ST_INT;
            cnt_nxt   = '0;
          end
        end
        ST_INT: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_W'(INTEG - 1)) begin           // [R6]
            state_nxt = ST_DEINT;
            cnt_nxt   = '0;
            neg_nxt   = neg_s;
          end
        end
        ST_DEINT: begin
          cnt_nxt = cnt_r + 1'b1;                         // [R7]
          if (zero_s || cnt_r == CNT_W'(OVER_COUNTS)) begin
            state_nxt      = ST_AZ_END;                   // [R8]
            disp_nxt.count = RES_W'(cnt_r);               // [R18]
            disp_nxt.neg   = neg_r;
            disp_nxt.over  = (cnt_r > CNT_W'(FULL_SCALE));
            cnt_nxt        = cnt_r;
          end
        end
        ST_AZ_END: begin
          if (cyc_r == CNT_W'(CYCLE - 1)) begin           // [R1]
            end_cyc = 1'b1;
            pend_nxt = 1'b0;
            cyc_nxt = '0;
            // only the level at cycle end counts        [R4]
            state_nxt = hold_s ? ST_AZ : ST_HELD;         // [R2] [R9]
          end
        end
        ST_HELD: begin
          if (pend_r) begin
            state_nxt = ST_AZ;                            // [R3]
            cyc_nxt   = '0;
            pend_nxt  = 1'b0;
          end
        end
        default: begin
          state_nxt = ST_HELD;
        end
      endcase
      if (end_cyc) begin
        post_run_nxt = 1'b1;
        post_nxt     = '0;
      end else if (post_run_r) begin
        post_nxt = post_r + 8'h01;
        if (post_r == 8'(STROBE_DLY - 1)) begin           // [R5]
          strobe_nxt   = 1'b1;
          post_run_nxt = 1'b0;
        end
      end
    end
    // a new trigger edge wins over consuming the old one
    if (state_r == ST_HELD && hold_s && !hold_q_r) begin
      pend_nxt = 1'b1;                                    // [R3]
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= ST_AZ;
      cyc_r          <= '0;
      cnt_r          <= '0;
      neg_r          <= 1'b0;
      o_disp         <= '0;
      hold_q_r       <= 1'b1;
      pend_r         <= 1'b0;
      post_r         <= '0;
      post_run_r     <= 1'b0;
      o_digit_strobe <= 1'b0;
      o_sig_sw       <= 1'b0;
      o_ref_sw       <= 1'b0;
      o_az_sw        <= 1'b1;
    end else if (i_ce) begin
      state_r        <= state_nxt;
      cyc_r          <= cyc_nxt;
      cnt_r          <= cnt_nxt;
      neg_r          <= neg_nxt;
      o_disp         <= disp_nxt;
      hold_q_r       <= hold_s;
      pend_r         <= pend_nxt;
      post_r         <= post_nxt;
      post_run_r     <= post_run_nxt;
      o_digit_strobe <= strobe_nxt;
      o_sig_sw       <= (state_nxt == ST_INT);
      o_ref_sw       <= (state_nxt == ST_DEINT);          // [R6]
      o_az_sw        <= (state_nxt != ST_INT) && (state_nxt != ST_DEINT);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = '0;
    if (i_bus.wr && i_bus.addr == ADDR_CTRL) begin
      ctrl_nxt = i_bus.wdata[3:0];
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_CTRL:   rdata_nxt[3:0] = ctrl_r;
        ADDR_STATUS: begin
          rdata_nxt[ST_DEINT_B] = (state_r == ST_DEINT);
          rdata_nxt[ST_INT_B]   = (state_r == ST_INT);
          rdata_nxt[ST_AZ_B]    = (state_r == ST_AZ) ||
                                  (state_r == ST_AZ_END);
          rdata_nxt[ST_OVER_B]  = o_disp.over;
          rdata_nxt[ST_HOLD_B]  = (state_r == ST_HELD);
        end
        ADDR_RESULT: begin
          rdata_nxt[RES_W-1:0]  = o_disp.count;
          rdata_nxt[RES_NEG_B]  = o_disp.neg;
          rdata_nxt[RES_OVER_B] = o_disp.over;
        end
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RST;
      o_rdata   <= '0;
      o_ref_ext <= 1'b0;
    end else if (i_ce) begin
      ctrl_r    <= ctrl_nxt;
      o_rdata   <= rdata_nxt;
      o_ref_ext <= ctrl_nxt[CTRL_RATIO];                  // [R10]
    end
  end

  // ----------------------------------------------------------------
  // display control
  // ----------------------------------------------------------------
  dsas_display #(
    .FLASH (FLASH)
  ) u_disp (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (rst_n),
    .i_ce        (i_ce),
    .i_tick      (tick_r),
    .i_disp      (o_disp),
    .i_blank_n   (blank_s),
    .i_dp_sel_n  (sync_q[7:4]),
    .i_jumper_en (ctrl_r[CTRL_JEN]),
    .i_jumper    (dsas_dp_e'(ctrl_r[CTRL_JSEL +: 2])),
    .o_digit_en  (o_digit_en),
    .o_sign_on   (o_sign_on),
    .o_dp        (o_dp)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cycle_bound;
    @(posedge i_core_clk) disable iff (!rst_n)
      cyc_r <= CNT_W'(CYCLE - 1);
  endproperty
  a_cycle_bound: assert property (p_cycle_bound) // [R1]
    else $error("cycle counter past cycle length");

  property p_int_len;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r == ST_INT) |-> (cnt_r < CNT_W'(INTEG));
  endproperty
  a_int_len: assert property (p_int_len) // [R6]
    else $error("integrate phase too long");

  property p_deint_clear;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r == ST_DEINT && $past(state_r) == ST_INT)
        |-> (cnt_r == '0) && o_ref_sw && !o_sig_sw;
  endproperty
  a_deint_clear: assert property (p_deint_clear) // [R6]
    else $error("counter not cleared on reference switch");

  property p_az_start;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r == ST_INT && $past(state_r) == ST_AZ)
        |-> (cyc_r == CNT_W'(AZ_LEN));
  endproperty
  a_az_start: assert property (p_az_start) // [R3]
    else $error("opening auto-zero length out of range");

  property p_held_stays;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r == ST_HELD && !pend_r) |=> (state_r == ST_HELD);
  endproperty
  a_held_stays: assert property (p_held_stays) // [R9]
    else $error("left hold without a trigger");

  property p_strobe_delay;
    @(posedge i_core_clk) disable iff (!rst_n)
      $rose(o_digit_strobe) |-> (post_r == 8'(STROBE_DLY));
  endproperty
  a_strobe_delay: assert property (p_strobe_delay) // [R5]
    else $error("digit strobe not 101 counts after cycle end");

  property p_latch;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r == ST_AZ_END && $past(state_r) == ST_DEINT)
        |-> (o_disp.count == RES_W'(cnt_r)) && o_az_sw;
  endproperty
  a_latch: assert property (p_latch) // [R18]
    else $error("result not latched after deintegrate");

  property p_stable_disp;
    @(posedge i_core_clk) disable iff (!rst_n)
      (state_r != ST_DEINT) |=> $stable(o_disp);
  endproperty
  a_stable_disp: assert property (p_stable_disp) // [R2]
    else $error("display changed outside deintegrate end");

endmodule

// file: src/dsas_pkg.sv
// dual-slope converter sequencer: shared constants and carrier types
// assumes a 25 MHz core clock and a plain one-cycle register port
package dsas_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CORE_HZ      = 25000000;
  localparam int unsigned OSC_HZ       = 100000;
  localparam int unsigned OSC_DIV      = CORE_HZ / OSC_HZ;
  localparam int unsigned OSC_HALF     = OSC_DIV / 2;

  // ----------------------------------------------------------------
  // conversion counts, in oscillator counts, and counter widths in bits
  // ----------------------------------------------------------------
  localparam int unsigned CYCLE_COUNTS = 40002;
  localparam int unsigned INT_COUNTS   = 10000;
  localparam int unsigned AZ_MIN       = 9001;
  localparam int unsigned AZ_MAX       = 10001;
  localparam int unsigned AZ_START     = 10000;
  localparam int unsigned FULL_SCALE   = 19999;
  localparam int unsigned OVER_COUNTS  = FULL_SCALE + 1;
  localparam int unsigned STROBE_DLY   = 101;
  localparam int unsigned FLASH_TICKS  = 20000;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned RES_W        = 15;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_RESULT   = 4'h8;
  localparam int unsigned CTRL_JEN     = 0;
  localparam int unsigned CTRL_JSEL    = 1;
  localparam int unsigned CTRL_RATIO   = 3;
  localparam logic [3:0] CTRL_RST      = 4'h0;
  localparam int unsigned ST_DEINT_B   = 0;
  localparam int unsigned ST_INT_B     = 1;
  localparam int unsigned ST_AZ_B      = 2;
  localparam int unsigned ST_OVER_B    = 3;
  localparam int unsigned ST_HOLD_B    = 4;
  localparam int unsigned RES_NEG_B    = 16;
  localparam int unsigned RES_OVER_B   = 17;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [3:0]        addr;
    logic [31:0]       wdata;
  } dsas_bus_s;

  typedef struct packed {
    logic              neg;
    logic              over;
    logic [RES_W-1:0]  count;
  } dsas_result_s;

  typedef enum logic [1:0] {
    DP_1P9999,
    DP_19P999,
    DP_199P99,
    DP_1999P9
  } dsas_dp_e;

endpackage

// file: src/dsas_sync.sv
// dual-slope converter sequencer: three-stage input synchroniser
// assumes asynchronous pins; output moves once stages two and three agree
`timescale 1ns/10ps
module dsas_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  import dsas_pkg::*;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_nxt;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : o_sync[i];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      s3_r   <= RST_VAL;
      o_sync <= RST_VAL;
    end else if (i_ce) begin
      s1_r   <= i_async;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      o_sync <= out_nxt;
    end
  end

endmodule

// file: src/dsas_display.sv
// dual-slope converter sequencer: digit blanking, flashing, decimal point
// assumes synchronised blank and select inputs and a 100 kHz count tick
`timescale 1ns/10ps
module dsas_display #(
  parameter int unsigned FLASH = dsas_pkg::FLASH_TICKS
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  input  wire logic                 i_tick,
  input  wire dsas_pkg::dsas_result_s i_disp,
  input  wire logic                 i_blank_n,
  input  wire logic [3:0]           i_dp_sel_n,
  input  wire logic                 i_jumper_en,
  input  wire dsas_pkg::dsas_dp_e   i_jumper,
  output logic      [4:0]           o_digit_en,
  output logic                      o_sign_on,
  output logic      [3:0]           o_dp
);
  import dsas_pkg::*;

  logic [15:0] flash_cnt_r;
  logic [15:0] flash_cnt_nxt;
  logic        flash_r;
  logic        flash_nxt;
  logic        dark;
  logic [3:0]  dp_pos;
  logic [4:0]  digit_nxt;

  // ----------------------------------------------------------------
  // flash timebase and outputs
  // ----------------------------------------------------------------
  always_comb begin
    flash_cnt_nxt = flash_cnt_r;
    flash_nxt     = flash_r;
    if (i_tick) begin
      if (flash_cnt_r == 16'(FLASH - 1)) begin
        flash_cnt_nxt = '0;
        flash_nxt     = ~flash_r;
      end else begin
        flash_cnt_nxt = flash_cnt_r + 16'h0001;
      end
    end
    dark = i_disp.over & flash_r;                         // [R12] [R16]
    // connector ties win, jumper else, exactly one lit unless the overrange flash is dark
    if (!i_dp_sel_n[0]) begin                             // [R13]
      dp_pos = 4'h1;
    end else if (!i_dp_sel_n[1]) begin
      dp_pos = 4'h2;
    end else if (!i_dp_sel_n[2]) begin
      dp_pos = 4'h4;
    end else if (!i_dp_sel_n[3]) begin
      dp_pos = 4'h8;
    end else if (i_jumper_en) begin
      dp_pos = 4'(4'h1 << i_jumper);
    end else begin
      dp_pos = 4'h1;
    end
    digit_nxt[4]   = 1'b1;                                // [R15]
    digit_nxt[3:0] = {4{i_blank_n & ~dark}};              // [R11] [R16]
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
      o_digit_en  <= 5'h1F;
      o_sign_on   <= 1'b1;
      o_dp        <= 4'h1;
    end else if (i_ce) begin
      flash_cnt_r <= flash_cnt_nxt;
      flash_r     <= flash_nxt;
      o_digit_en  <= digit_nxt;
      o_sign_on   <= ~dark;                               // [R12]
      o_dp        <= dark ? 4'h0 : dp_pos;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_dp_onehot;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_dp != 4'h0) |-> $onehot(o_dp);
  endproperty
  a_dp_onehot: assert property (p_dp_onehot) // [R13]
    else $error("more than one decimal point lit");

  property p_lead_digit;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_digit_en[4];
  endproperty
  a_lead_digit: assert property (p_lead_digit) // [R15]
    else $error("leading digit was blanked");

  property p_blank;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !i_blank_n) |=> (o_digit_en[3:0] == 4'h0);
  endproperty
  a_blank: assert property (p_blank) // [R11]
    else $error("digits shown while blank input low");

  property p_dp_kept;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !i_disp.over) |=> (o_dp != 4'h0) && o_sign_on;
  endproperty
  a_dp_kept: assert property (p_dp_kept) // [R12]
    else $error("sign or point dark without overrange");

endmodule

// file: tb/dsas_cmp_model.sv
// partner: integrator and comparator as the sequencer sees them
// assumes registered switch outputs and the 100 kHz oscillator output
`timescale 1ns/10ps
module dsas_cmp_model #(
  parameter int DEINT = 25
) (
  input  wire logic i_core_clk,
  input  wire logic i_osc,
  input  wire logic i_sig_sw,
  input  wire logic i_ref_sw,
  output logic      o_cmp_zero
);
  logic osc_d = 1'b0;
  int   k     = 0;
  // ----------------------------------------------------------------
  // ramp down counts oscillator ticks while the reference is applied
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    osc_d <= i_osc;
    if (!i_ref_sw)
      k <= 0;
    else if (i_osc && !osc_d)
      k <= k + 1;
  end
  assign o_cmp_zero = !(i_sig_sw || (i_ref_sw && k < DEINT));
endmodule

// file: tb/dsas_seq_tb_top.sv
// bench: sequencer driven through its pins and register port
// assumes the comparator partner model and shortened cycle counts
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module dsas_seq_tb_top;
  import dsas_pkg::*;
  localparam int CYC = 160;
  localparam int INTEG = 40;
  localparam int AZ = 40;
  localparam int DEINT = 25;
  localparam int T = 250;
  logic          i_core_clk = 1'b0;
  logic          i_resetn   = 1'b0;
  logic          i_hold     = 1'b1;
  logic          i_blank_n  = 1'b1;
  logic [3:0]    i_dp_sel_n = 4'hF;
  dsas_bus_s     i_bus      = '0;
  wire logic     i_cmp_zero;
  logic [31:0]   o_rdata;
  logic          o_osc_100k, o_sig_sw, o_ref_sw, o_az_sw, o_ref_ext;
  logic          o_digit_strobe, o_sign_on;
  dsas_result_s  o_disp;
  logic [4:0]    o_digit_en;
  logic [3:0]    o_dp;
  logic [31:0]   d;
  int            cyc = 0, t0 = 0, checked = 0, err_total = 0;
  wire logic [2:0] mon = {o_digit_strobe, o_ref_sw, o_sig_sw};

  dsas_seq #(.CYCLE(CYC), .INTEG(INTEG), .AZ_LEN(AZ), .FLASH(4)) u_dsas_seq (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(1'b1),
    .i_bus(i_bus), .i_hold(i_hold), .i_blank_n(i_blank_n),
    .i_cmp_zero(i_cmp_zero), .i_sig_neg(1'b0), .i_dp_sel_n(i_dp_sel_n),
    .o_rdata(o_rdata), .o_osc_100k(o_osc_100k), .o_sig_sw(o_sig_sw),
    .o_ref_sw(o_ref_sw), .o_az_sw(o_az_sw), .o_ref_ext(o_ref_ext),
    .o_digit_strobe(o_digit_strobe), .o_disp(o_disp),
    .o_digit_en(o_digit_en), .o_sign_on(o_sign_on), .o_dp(o_dp));
  dsas_cmp_model #(.DEINT(DEINT)) u_dsas_cmp_model (
    .i_core_clk(i_core_clk), .i_osc(o_osc_100k), .i_sig_sw(o_sig_sw),
    .i_ref_sw(o_ref_sw), .o_cmp_zero(i_cmp_zero));

  // ----------------------------------------------------------------
  // clock, cycle count and hang limit
  // ----------------------------------------------------------------
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // register port and wait helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_core_clk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 v = o_rdata;
  endtask
  task automatic wt(input int b, input logic v, input int lim);
    int c;
    c = 0;
    while (mon[b] !== v && c < lim) begin
      @(posedge i_core_clk);
      #1;
      c++;
    end
    `CHK(mon[b], v);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK(o_digit_en, 5'h1F);
    `CHK(o_dp, 4'h1);
    `CHK(o_az_sw, 1'b1);
    d[0] = o_osc_100k;
    repeat (OSC_HALF) @(posedge i_core_clk);
    #1;
    `CHK(o_osc_100k, ~d[0]);
    wr(ADDR_CTRL, 32'h0000000F);
    #1;
    `CHK(o_ref_ext, 1'b1);
    repeat (4) @(posedge i_core_clk);
    #1;
    `CHK(o_dp, 4'h8);
    rd(ADDR_CTRL, d);
    `CHK(d, 32'h0000000F);
    rd(4'hC, d);
    `CHK(d, 32'h00000000);
    @(posedge i_core_clk);
    i_dp_sel_n <= 4'hD;
    i_blank_n <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    #1;
    `CHK(o_dp, 4'h2);
    `CHK(o_digit_en, 5'h10);
    `CHK(o_sign_on, 1'b1);
    @(posedge i_core_clk);
    i_dp_sel_n <= 4'hF;
    i_blank_n <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    #1;
    `CHK(o_ref_ext, 1'b0);
    wt(0, 1'b1, 20000);
    t0 = cyc;
    repeat (20) @(posedge i_core_clk);
    i_hold <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    i_hold <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_hold <= 1'b0;
    wt(0, 1'b0, 20000);
    `CHK(cyc - t0, INTEG * T);
    wt(1, 1'b0, 20000);
    `CHK(o_disp.count inside {[DEINT - 1:DEINT + 1]}, 1'b1);
    `CHK(o_disp.over, 1'b0);
    wt(2, 1'b1, 40000);
    `CHK(cyc - t0, (CYC - AZ + 101) * T);
    `CHK(o_sig_sw, 1'b0);
    rd(ADDR_STATUS, d);
    `CHK(d[ST_HOLD_B], 1'b1);
    `CHK(d[ST_AZ_B], 1'b0);
    `CHK(o_az_sw, 1'b1);
    @(posedge i_core_clk);
    i_hold <= 1'b1;
    #1;
    t0 = cyc;
    repeat (10) @(posedge i_core_clk);
    i_hold <= 1'b0;
    wt(0, 1'b1, 12000);
    `CHK((cyc - t0) inside {[AZ * T:AZ * T + T + 10]}, 1'b1);
    print_verdict();
  end
endmodule
